// [core/standby_pkg.sv]
// shared constants, modes and carriers of the standby controller
package standby_pkg;
	localparam logic [3:0] ADR_DEPTH = 4'h0;
	localparam logic [3:0] ADR_PSC = 4'h4;
	localparam logic [3:0] ADR_PROT = 4'h8;
	localparam logic [3:0] ADR_STAT = 4'hC;
	localparam logic [7:0] DEPTH_RST = 8'h00;
	localparam logic [7:0] PSC_RST = 8'h00;
	localparam int DEPTH_BIT = 0;
	localparam int STB_BIT = 1;
	localparam int MASKABLE_WAKE_DISABLE_BIT = 4;
	localparam int STAT_ARMED_BIT = 2;
	localparam int PRIO_W = 3;

	typedef enum logic [1:0] {
		NORMAL,
		HALT,
		IDLE,
		STOP
	} mode_e;

	// wake requests from the interrupt controller
	typedef struct packed {
		logic nmi;
		logic maskable;
		logic idle_src;
		logic [PRIO_W-1:0] prio;
	} wake_req_s;

	// what the cpu is currently servicing
	typedef struct packed {
		logic in_service;
		logic [PRIO_W-1:0] prio;
		logic int_disable;
	} service_s;

	typedef struct packed {
		logic pin;
		logic wdt;
		logic lvi;
		logic poc;
	} reset_src_s;
endpackage : standby_pkg

// [core/standby_halt_idle_control.sv]
// standby controller: halt, idle and stop entry, wake decision, clock enables
// Behaviour
// [RL1] 8-bit depth select register, byte accessible, resets to zero.
// [RL2] depth bit 0 selects idle, 1 selects stop.
// [RL3] software writes zero to depth select bits 1 to 7.
// [RL4] depth bit matters only when the standby request bit is set.
// [RL5] halt entered only by halt instruction in normal operation.
// [RL6] halt gates only the cpu clock; peripherals keep their clock.
// [RL7] halt keeps peripherals running and all state preserved.
// [RL8] software places five nops after halt.
// [RL9] halt with pending unmasked interrupt enters then leaves at once.
// [RL10] halt left on watchdog nmi, unmasked maskable irq, or any reset.
// [RL11] wake from halt happens whatever the interrupt priority.
// [RL12] maskable wake disable bit set blocks maskable wake from halt.
// [RL13] lower or equal priority wake resumes next instruction, request left pending.
// [RL14] higher priority or nmi wake acknowledges and branches to handler.
// [RL15] interrupts disabled: maskable wake resumes, nmi always branches.
// [RL16] reset source ending halt runs the ordinary reset sequence.
// [RL17] idle entered when depth bit 0 and standby request then set.
// [RL18] idle stops cpu and peripheral clocks, oscillator and pll run.
// [RL19] idle retains all internal state.
// [RL20] leaving idle resumes at once with no stabilisation wait.
// [RL21] software places five nops after the store requesting idle.
// [RL22] power save control holds standby request and maskable wake disable.
// [RL23] software sets clock control to 03H, depth bit, then standby request.
// [RL24] power save control written only through the protected sequence.
// [RL25] idle released by pin, low-voltage, slave serial irqs or resets.
// [RL26] clock enables change without truncated pulses.
`timescale 1ns/1ps
module standby_halt_idle_control
	import standby_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic halt_exec,
	input wire wake_req_s wake,
	input wire service_s svc,
	input wire reset_src_s rst_src,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_stop,
	output logic irq_ack,
	output logic resume_next,
	output logic core_reset_req,
	output mode_e mode_out
);
	logic [7:0] standby_depth_select;
	logic [7:0] power_save_control;
	logic prot_armed;
	mode_e mode;
	mode_e next_mode;
	logic next_ack;
	logic next_resume;
	logic req;
	logic wr;
	logic wr_depth;
	logic wr_psc;
	logic wr_prot;
	logic rst_hit;
	logic halt_mask_ok;
	logic idle_mask_ok;
	logic take_handler;
	logic [7:0] rd_byte;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign wr_depth = wr & (wb_adr_i == ADR_DEPTH);
	assign wr_psc = wr & (wb_adr_i == ADR_PSC);
	assign wr_prot = wr & (wb_adr_i == ADR_PROT);

	// the watchdog is stopped in idle and stop, so its overflow cannot end them
	assign rst_hit = rst_src.pin | rst_src.lvi | rst_src.poc | (rst_src.wdt & (mode == NORMAL | mode == HALT)); // RL10 RL25

	assign halt_mask_ok = wake.maskable & ~power_save_control[MASKABLE_WAKE_DISABLE_BIT]; // RL12
	assign idle_mask_ok = wake.idle_src & ~power_save_control[MASKABLE_WAKE_DISABLE_BIT]; // RL25
	// priority 0 is highest, so a smaller code outranks the one in service
	assign take_handler = ~svc.int_disable & (~svc.in_service | (wake.prio < svc.prio)); // RL13 RL14 RL15

	// bus slave: ack one cycle after the request, dropped the next cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		case (wb_adr_i)
			ADR_DEPTH: rd_byte = standby_depth_select;
			ADR_PSC: rd_byte = power_save_control;
			ADR_STAT: rd_byte = {5'h00, prot_armed, mode};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req & ~wb_we_i) begin
			wb_dat_o <= {24'h00_0000, rd_byte};
		end
	end

	// depth select keeps all eight bits as written
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			standby_depth_select <= DEPTH_RST; // RL1
		end else if (rst_hit) begin
			standby_depth_select <= DEPTH_RST; // RL16
		end else if (wr_depth) begin
			standby_depth_select <= wb_dat_i[7:0]; // RL1
		end
	end

	// the command register arms exactly one following write
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prot_armed <= 1'b0;
		end else if (rst_hit) begin
			prot_armed <= 1'b0;
		end else if (wr_prot) begin
			prot_armed <= 1'b1; // RL24
		end else if (wr) begin
			prot_armed <= 1'b0; // RL24
		end
	end

	// only the two defined bits are stored; the rest read as zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			power_save_control <= PSC_RST;
		end else if (rst_hit) begin
			power_save_control <= PSC_RST; // RL16
		end else if (wr_psc & prot_armed) begin
			power_save_control <= PSC_RST;
			power_save_control[STB_BIT] <= wb_dat_i[STB_BIT]; // RL22
			power_save_control[MASKABLE_WAKE_DISABLE_BIT] <= wb_dat_i[MASKABLE_WAKE_DISABLE_BIT]; // RL22
		end else if ((mode == IDLE | mode == STOP) & next_mode == NORMAL) begin
			// standby request drops on release so the next store must ask again
			power_save_control[STB_BIT] <= 1'b0;
		end
	end

	always_comb begin
		next_mode = mode;
		next_ack = 1'b0;
		next_resume = 1'b0;
		case (mode)
			NORMAL: begin
				if (power_save_control[STB_BIT]) begin
					// depth bit is consulted only here, under the request bit
					next_mode = standby_depth_select[DEPTH_BIT] ? STOP : IDLE; // RL2 RL4 RL17
				end else if (halt_exec) begin
					next_mode = HALT; // RL5
				end
			end
			HALT: begin
				// a request already pending wakes in the first halt cycle
				if (wake.nmi) begin
					next_mode = NORMAL; // RL9 RL10 RL11
					next_ack = 1'b1; // RL14 RL15
				end else if (halt_mask_ok) begin
					next_mode = NORMAL; // RL9 RL10 RL11
					next_ack = take_handler; // RL14
					next_resume = ~take_handler; // RL13 RL15
				end
			end
			IDLE, STOP: begin
				if (idle_mask_ok) begin
					// no stabilisation count in idle or stop, though osc_stop is set in stop
					next_mode = NORMAL; // RL20 RL25
					next_ack = take_handler; // RL14
					next_resume = ~take_handler; // RL13 RL15
				end
			end
			default: next_mode = NORMAL;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode <= NORMAL;
		end else if (rst_hit) begin
			mode <= NORMAL; // RL16
		end else begin
			mode <= next_mode;
		end
	end

	// enables are registered and feed a latch-based gate outside, so the
	// gated clock only starts or stops on a whole low phase
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			osc_stop <= 1'b0;
		end else if (rst_hit) begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			osc_stop <= 1'b0;
		end else begin
			cpu_clk_en <= (next_mode == NORMAL); // RL6 RL18 RL26
			periph_clk_en <= (next_mode == NORMAL) | (next_mode == HALT); // RL6 RL7 RL18 RL19 RL26
			osc_stop <= (next_mode == STOP);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_ack <= 1'b0;
			resume_next <= 1'b0;
			mode_out <= NORMAL;
		end else if (rst_hit) begin
			irq_ack <= 1'b0;
			resume_next <= 1'b0;
			mode_out <= NORMAL;
		end else begin
			irq_ack <= next_ack; // RL14
			resume_next <= next_resume; // RL13
			mode_out <= next_mode;
		end
	end

	// reset request held for as long as pin, lvi or poc is active, or wdt outside idle and stop
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			core_reset_req <= 1'b0;
		end else begin
			core_reset_req <= rst_hit; // RL16
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	depth_reset_a: assert property ( // RL1
		rst_hit |=> standby_depth_select == 8'h00)
		else $error("depth select not cleared by reset source");

	depth_write_a: assert property ( // RL1
		wr_depth & ~rst_hit |=> standby_depth_select == $past(wb_dat_i[7:0]))
		else $error("depth select write lost");

	stop_entry_a: assert property ( // RL2
		mode == NORMAL & power_save_control[STB_BIT] & standby_depth_select[DEPTH_BIT] & ~rst_hit
		|=> mode == STOP & osc_stop & ~periph_clk_en)
		else $error("stop not entered");

	depth_ignored_a: assert property ( // RL4
		mode == NORMAL & ~power_save_control[STB_BIT] & ~halt_exec & ~rst_hit |=> mode == NORMAL)
		else $error("standby entered without request bit");

	halt_entry_a: assert property ( // RL5
		mode == NORMAL & halt_exec & ~power_save_control[STB_BIT] & ~rst_hit
		|=> mode == HALT & ~cpu_clk_en & periph_clk_en)
		else $error("halt not entered with cpu clock gated only");

	halt_only_normal_a: assert property ( // RL5
		mode != NORMAL & $past(mode) != NORMAL |-> mode != HALT | $past(mode) == HALT)
		else $error("halt entered from a standby state");

	halt_pending_a: assert property ( // RL9
		mode == NORMAL & halt_exec & ~power_save_control[STB_BIT] & wake.nmi & ~rst_hit
		##1 wake.nmi & ~rst_hit |=> mode == NORMAL & cpu_clk_en & irq_ack)
		else $error("pending nmi did not end halt at once");

	mask_block_a: assert property ( // RL12
		mode == HALT & ~wake.nmi & power_save_control[MASKABLE_WAKE_DISABLE_BIT] & ~rst_hit |=> mode == HALT)
		else $error("maskable wake not blocked");

	low_prio_resume_a: assert property ( // RL13
		mode == HALT & ~wake.nmi & halt_mask_ok & svc.in_service & ~svc.int_disable
		& wake.prio >= svc.prio & ~rst_hit |=> resume_next & ~irq_ack ##1 ~resume_next)
		else $error("low priority wake not resumed");

	high_prio_ack_a: assert property ( // RL14
		mode == HALT & ~wake.nmi & halt_mask_ok & ~svc.int_disable
		& (~svc.in_service | wake.prio < svc.prio) & ~rst_hit |=> irq_ack & ~resume_next)
		else $error("high priority wake not acknowledged");

	disabled_resume_a: assert property ( // RL15
		mode == IDLE & idle_mask_ok & svc.int_disable & ~rst_hit |=> resume_next & cpu_clk_en & ~irq_ack)
		else $error("disabled wake took handler");

	reset_exit_a: assert property ( // RL16
		rst_hit |=> mode == NORMAL & core_reset_req & cpu_clk_en & power_save_control == 8'h00)
		else $error("reset source did not reset controller");

	idle_gate_a: assert property ( // RL18
		mode == IDLE & $past(mode) == IDLE |-> ~cpu_clk_en & ~periph_clk_en & ~osc_stop)
		else $error("idle clock gating wrong");

	idle_release_a: assert property ( // RL20
		mode == IDLE & idle_mask_ok & ~rst_hit |=> mode == NORMAL & cpu_clk_en & periph_clk_en)
		else $error("idle release not immediate");

	prot_write_a: assert property ( // RL24
		wr_psc & ~prot_armed & ~rst_hit & mode == NORMAL |=> $stable(power_save_control[MASKABLE_WAKE_DISABLE_BIT]))
		else $error("unprotected write changed power save control");

	enable_glitch_a: assert property ( // RL26
		$changed(cpu_clk_en) |-> $past(next_mode) == mode | $past(rst_hit))
		else $error("cpu enable changed outside a mode step");

	ack_pulse_a: assert property ( // RL1
		wb_ack_o |=> ~wb_ack_o)
		else $error("bus ack longer than one cycle");

	read_upper_a: assert property ( // RL1
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");

	idle_entry_a: assert property ( // RL17
		mode == NORMAL & power_save_control[STB_BIT] & ~standby_depth_select[DEPTH_BIT] & ~rst_hit
		|=> mode == IDLE & ~cpu_clk_en & ~periph_clk_en & ~osc_stop)
		else $error("idle not entered");

	halt_ignored_a: assert property ( // RL5
		mode == IDLE & halt_exec & ~idle_mask_ok & ~rst_hit |=> mode == IDLE)
		else $error("halt taken outside normal operation");

	halt_nmi_wake_a: assert property ( // RL10 RL15
		mode == HALT & wake.nmi & ~rst_hit |=> mode == NORMAL & irq_ack & ~resume_next)
		else $error("nmi did not wake halt into handler");

	halt_periph_a: assert property ( // RL6 RL7
		mode == HALT |-> periph_clk_en & ~cpu_clk_en & ~osc_stop)
		else $error("halt gated more than the cpu clock");

	idle_other_a: assert property ( // RL25
		mode == IDLE & ~wake.idle_src & ~rst_hit |=> mode == IDLE)
		else $error("idle left by a source that may not release it");

	stb_clear_a: assert property ( // RL20
		mode == IDLE & idle_mask_ok & ~rst_hit & ~(wr_psc & prot_armed) |=> ~power_save_control[STB_BIT])
		else $error("standby request kept after release");

	stop_release_a: assert property ( // RL2 RL20
		mode == STOP & idle_mask_ok & ~rst_hit |=> mode == NORMAL & ~osc_stop & cpu_clk_en)
		else $error("stop not released");

	wake_pulse_a: assert property ( // RL13 RL14
		irq_ack |-> ~resume_next ##1 ~irq_ack)
		else $error("acknowledge not a lone pulse");

	psc_unused_a: assert property ( // RL22
		(power_save_control & 8'hED) == 8'h00)
		else $error("undefined power save bits set");

	prot_arm_a: assert property ( // RL24
		wr_prot & ~rst_hit |=> prot_armed)
		else $error("command write did not arm");

	prot_disarm_a: assert property ( // RL24
		wr & ~wr_prot & ~rst_hit |=> ~prot_armed)
		else $error("arming survived a later write");

	any_prio_wake_a: assert property ( // RL11
		mode == HALT & halt_mask_ok & ~rst_hit |=> mode == NORMAL & cpu_clk_en)
		else $error("maskable wake refused by priority");
endmodule : standby_halt_idle_control

// [testbench/cpu_model.sv]
// cpu core and interrupt controller model driving halt, wake, service and reset inputs
`timescale 1ns/1ps
module cpu_model
	import standby_pkg::*;
(
	input wire logic sys_clk,
	input wire logic irq_ack,
	output logic halt_exec,
	output wake_req_s wake,
	output service_s svc,
	output reset_src_s rst_src
);
	initial begin
		halt_exec = 1'b0;
		wake = '0;
		svc = '0;
		rst_src = '0;
	end
	// an acknowledged nmi or maskable request leaves the pending set, a resumed one stays pending
	always @(posedge sys_clk) begin
		if (irq_ack) begin
			wake.nmi <= 1'b0;
			wake.maskable <= 1'b0;
		end
	end
	task automatic halt_op;
		// idle slots stand in for the nops that follow each wake or store
		repeat (5) @(posedge sys_clk);
		halt_exec <= 1'b1;
		@(posedge sys_clk);
		halt_exec <= 1'b0;
	endtask : halt_op
	task automatic set_wake(input logic [5:0] w);
		@(posedge sys_clk);
		wake <= w;
	endtask : set_wake
	task automatic set_svc(input logic [4:0] s);
		@(posedge sys_clk);
		svc <= s;
	endtask : set_svc
	task automatic set_rst(input logic [3:0] r);
		@(posedge sys_clk);
		rst_src <= r;
	endtask : set_rst
endmodule : cpu_model

// [testbench/testbench.sv]
// self-checking bench: registers, halt wake decisions, idle, stop and the pin reset source
`timescale 1ns/1ps
module testbench
	import standby_pkg::*;
;
	logic sys_clk, nrst, cyc, stb, we, ack, halt_exec, cpu_en, per_en, osc_stop;
	logic irq_ack, resume_next, core_reset_req;
	logic [3:0] adr, sel;
	logic [31:0] dat, q, dat_o;
	wake_req_s wake;
	service_s svc;
	reset_src_s rst_src;
	mode_e mode;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	// maskable at several priorities against service states, nmi in the fifth row
	logic [5:0] wk [6] = '{6'h12, 6'h12, 6'h11, 6'h13, 6'h20, 6'h17};
	logic [4:0] sv [6] = '{5'h01, 5'h14, 5'h14, 5'h14, 5'h01, 5'h00};
	logic [1:0] ex [6] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2};
	standby_halt_idle_control standby_halt_idle_control_inst (.sys_clk(sys_clk), .nrst(nrst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dat_o), .halt_exec(halt_exec), .wake(wake),
		.svc(svc), .rst_src(rst_src), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
		.osc_stop(osc_stop), .irq_ack(irq_ack), .resume_next(resume_next),
		.core_reset_req(core_reset_req), .mode_out(mode));
	cpu_model cpu_model_inst (.sys_clk(sys_clk), .irq_ack(irq_ack), .halt_exec(halt_exec),
		.wake(wake), .svc(svc), .rst_src(rst_src));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			finish_test;
		end
	end
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("bus answer missing");
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic prot_psc(input logic [7:0] v);
		bus(1'b1, ADR_PROT, 8'h00);
		bus(1'b1, ADR_PSC, v);
	endtask : prot_psc
	task automatic st(input string n, input logic [4:0] e);
		check(n, {mode, cpu_en, per_en, osc_stop}, e);
	endtask : st
	task automatic wait_mode(input mode_e m);
		int n;
		n = 0;
		while (mode !== m && n < 10) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : wait_mode
	task automatic wake_step(input logic [5:0] w);
		cpu_model_inst.set_wake(w);
		@(posedge sys_clk);
		#1;
	endtask : wake_step
	initial begin
		nrst = 1'b0;
		{cyc, stb, we, adr, dat} = '0;
		sel = 4'hF;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(1'b0, ADR_DEPTH, 8'h00);
		check("depth reset", q, 32'h0);
		// a write without the low byte lane must leave the register alone
		sel <= 4'h0;
		bus(1'b1, ADR_DEPTH, 8'h55);
		sel <= 4'hF;
		bus(1'b0, ADR_DEPTH, 8'h00);
		check("depth sel off", q, 32'h0);
		bus(1'b0, ADR_PSC, 8'h00);
		check("psc reset", q, 32'h0);
		bus(1'b0, 4'h2, 8'h00);
		check("unmapped", q, 32'h0);
		bus(1'b1, ADR_PSC, 8'h02);
		bus(1'b0, ADR_PSC, 8'h00);
		check("psc unprotected", q, 32'h0);
		bus(1'b1, ADR_PROT, 8'h00);
		bus(1'b0, ADR_STAT, 8'h00);
		check("status armed", q, 32'h4);
		bus(1'b1, 4'h2, 8'h00);
		bus(1'b0, ADR_STAT, 8'h00);
		check("status disarmed", q, 32'h0);
		st("normal", {NORMAL, 3'h6});
		$display("test registers finished");
		for (int i = 0; i < 6; i++) begin
			cpu_model_inst.set_svc(sv[i]);
			cpu_model_inst.halt_op();
			#1 st("halt", {HALT, 3'h2});
			wake_step(wk[i]);
			st("woken", {NORMAL, 3'h6});
			check("wake pulse", {irq_ack, resume_next}, ex[i]);
			cpu_model_inst.set_wake(6'h00);
		end
		cpu_model_inst.set_svc(5'h01);
		cpu_model_inst.set_wake(6'h12);
		cpu_model_inst.halt_op();
		#1 st("pending halt", {HALT, 3'h2});
		@(posedge sys_clk);
		#1 st("pending wake", {NORMAL, 3'h6});
		cpu_model_inst.set_wake(6'h00);
		prot_psc(8'h10);
		bus(1'b0, ADR_PSC, 8'h00);
		check("psc mask", q, 32'h10);
		cpu_model_inst.halt_op();
		wake_step(6'h12);
		st("masked", {HALT, 3'h2});
		wake_step(6'h20);
		check("nmi ack", {irq_ack, resume_next, mode}, {2'h2, NORMAL});
		cpu_model_inst.set_wake(6'h00);
		prot_psc(8'h00);
		$display("test halt finished");
		bus(1'b1, ADR_DEPTH, 8'h00);
		prot_psc(8'h02);
		wait_mode(IDLE);
		st("idle", {IDLE, 3'h0});
		wake_step(6'h30);
		st("idle ignores", {IDLE, 3'h0});
		wake_step(6'h08);
		st("idle left", {NORMAL, 3'h6});
		cpu_model_inst.set_wake(6'h00);
		bus(1'b1, ADR_DEPTH, 8'h01);
		bus(1'b0, ADR_DEPTH, 8'h00);
		check("depth", q, 32'h1);
		st("depth alone", {NORMAL, 3'h6});
		prot_psc(8'h02);
		wait_mode(STOP);
		st("stop", {STOP, 3'h1});
		wake_step(6'h08);
		st("stop left", {NORMAL, 3'h6});
		cpu_model_inst.set_wake(6'h00);
		$display("test idle stop finished");
		cpu_model_inst.halt_op();
		cpu_model_inst.set_rst(4'h8);
		@(posedge sys_clk);
		#1 check("reset req", {core_reset_req, mode, cpu_en}, {1'b1, NORMAL, 1'b1});
		cpu_model_inst.set_rst(4'h0);
		bus(1'b0, ADR_DEPTH, 8'h00);
		check("depth cleared", q, 32'h0);
		$display("test reset source finished");
		finish_test;
	end
endmodule : testbench
